// >>> bench/dtp_monitor.sv
// checker of bus timing, read fields and request gating
// assumes a bind to dtp_top, one register per word
`timescale 1ns/1ns
module dtp_monitor
    import dtp_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // request
    input wire logic timer_a_ovf_irq
);
    logic ph_q, done_q, rd_q, mask_q;
    logic [7:0] idx_q;
    wire logic take = hsel && hready && htrans[1] && hreadyout;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////
    // phase of each taken transfer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            ph_q <= take;
            done_q <= ph_q;
        end
    end
    // address and direction of the open transfer
    always_ff @(posedge hclk)
    begin
        if (take)
        begin
            rd_q <= !hwrite;
            idx_q <= haddr[9:2];
        end
    end
    // mirror of the overflow gate bit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mask_q <= 1'b0;
        else if (ph_q && !rd_q && idx_q == IDX_MASK)
            mask_q <= hwdata[FLAG_A_OVF_BIT];
    end
    ////////////////////////////////////////////////////////////
    // bus steps
    sequence s_take;
        take;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_rd_done;
        done_q && rd_q;
    endsequence
    a_bus_wait: assert property (s_take |=> s_one_wait)
        else $error("wait state wrong");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_rdata_byte: assert property (s_rd_done |-> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_ctl_a_zero: assert property (s_rd_done ##0 (idx_q == IDX_A_CONTROL)
        |-> hrdata[7:3] == 5'h0)
        else $error("timer a control reads ones");
    a_ctl_b_zero: assert property (s_rd_done ##0
        (idx_q == IDX_B_CONTROL_TWO) |-> hrdata[6:4] == 3'h0)
        else $error("timer b control reads ones");
    a_unmapped_zero: assert property (s_rd_done ##0 (idx_q == 8'h00)
        |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_irq_gated: assert property (!mask_q |-> !timer_a_ovf_irq)
        else $error("request while masked");
    a_rdata_hold: assert property (!(done_q && rd_q) |-> $stable(hrdata))
        else $error("read data moved");
endmodule // dtp_monitor

bind dtp_top dtp_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .timer_a_ovf_irq);

// >>> bench/dtp_pulse_src.sv
// pulse source standing at the external count pin
// assumes the pin changes just after hclk rising edges
`timescale 1ns/1ns
module dtp_pulse_src
(
    // clock
    input wire logic hclk,
    // request: pulse count, pace, start
    input wire logic [7:0] num,
    input wire logic slow,
    input wire logic go,
    // pin and progress
    output logic count_input_pin,
    output logic busy
);
    int left = 0;
    logic pace = 1'b0;
    initial count_input_pin = 1'b0;
    initial busy = 1'b0;
    // halves of two or four core periods each
    always @(posedge hclk)
    begin
        if (go && !busy)
        begin
            pace = slow;
            left = num * (slow ? 8 : 4);
        end
        else if (left > 0)
            left = left - 1;
        count_input_pin <= pace ? left[2] : left[1];
        busy <= left > 0;
    end
endmodule // dtp_pulse_src

// >>> bench/dtp_top_tb.sv
// self-checking bench of the dual timer front end
// assumes dtp_top with its checker bound, a pulse source on the pin
`timescale 1ns/1ns
module dtp_top_tb
    import dtp_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic fast, fast_run, go, slow, busy, pin, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] num, q, q1;
    wire logic hready = hreadyout;
    int mismatches = 0, num_checks = 0, cyc = 0, nf = 0, el, dv, s;
    int mdl [int];
    int div [6] = '{0, 1, 8, 64, 256, 1024};
    logic [7:0] rl [10] = '{IDX_A_COUNT, IDX_A_CONTROL, IDX_B_CONTROL_ONE,
        IDX_B_CONTROL_TWO, IDX_B_COMPARE_A, IDX_B_COMPARE_B,
        IDX_B_COMPARE_TOP, IDX_PLL_CONTROL, IDX_MASK, IDX_FLAG};
    dtp_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .count_input_pin(pin), .fast_peripheral_timebase(fast),
        .timer_a_ovf_irq(irq));
    dtp_pulse_src u_src (.hclk, .num, .slow, .go,
        .count_input_pin(pin), .busy);
    ////////////////////////////////////////////////////////////
    // clock, cycle count and fast timebase
    always #25 hclk = !hclk;
    always @(negedge hclk)
        cyc++;
    always @(posedge hclk)
    begin
        if (fast_run && !fast)
            nf++;
        if (fast_run)
            fast <= !fast;
    end
    task automatic give_verdict;
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got,
        input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got);
        end
    endtask
    // wait until ready is high at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(negedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1)
        begin
            mismatches++;
            give_verdict();
        end
        @(posedge hclk);
    endtask
    task automatic xf(input logic w, input logic [7:0] i,
        input logic [7:0] d, output logic [7:0] r);
        hsel <= 1'b1;
        haddr <= {22'h0, i, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
        r = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        xf(1'b1, i, d, q);
        mdl[i] = d & (i == IDX_A_CONTROL ? 8'h07 :
            i == IDX_B_CONTROL_TWO ? 8'h8F : 8'hFF);
    endtask
    task automatic rdc(input logic [7:0] i);
        xf(1'b0, i, 8'h00, q);
        chk("reg", q, mdl[i]);
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        {hclk, hresetn, hsel, hwrite, fast, fast_run, go, slow} = 8'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        num = 8'h0;
        foreach (rl[i]) mdl[rl[i]] = 0;
        mdl[IDX_B_COMPARE_TOP] = 8'hFF;
        s = $urandom(79);
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, then an unmapped read
        foreach (rl[i]) rdc(rl[i]);
        xf(1'b0, 8'h00, 8'h00, q);
        chk("unmapped", q, 8'h00);
        // write and read straight back, reserved bits masked
        for (int j = 0; j < 3; j++)
            for (int i = 1; i < 7; i++)
            begin
                wr(rl[i], j == 0 ? 8'hFF : 8'($urandom));
                rdc(rl[i]);
            end
        // timer a stop and divided core taps
        for (int k = 0; k < 6; k++)
        begin
            wr(IDX_A_CONTROL, 8'(k) | 8'h08);
            wr(IDX_A_COUNT, 8'h00);
            el = cyc;
            repeat (3 * div[k] + 5) @(posedge hclk);
            xf(1'b0, IDX_A_COUNT, 8'h00, q);
            dv = int'(q) - (k == 0 ? 0 : (cyc - el) / div[k]);
            chk("tap", dv >= -1 && dv <= 1 && (k > 0 || q == 0), 1);
        end
        // timer a counting pin edges of both kinds
        for (int k = 6; k < 8; k++)
        begin
            wr(IDX_A_CONTROL, 8'(k));
            wr(IDX_A_COUNT, 8'h00);
            num <= 8'($urandom_range(20, 1));
            slow <= 1'($urandom);
            go <= 1'b1;
            @(posedge hclk);
            go <= 1'b0;
            @(posedge hclk);
            for (int n = 0; busy !== 1'b0; n++)
            begin
                if (n > 400)
                    chk("pin_busy", 1, 0);
                if (n > 400)
                    give_verdict();
                @(posedge hclk);
            end
            repeat (4) @(posedge hclk);
            xf(1'b0, IDX_A_COUNT, 8'h00, q);
            chk("pin", q, num);
        end
        // overflow flag, gated request, write-one clear
        wr(IDX_MASK, 8'h02);
        wr(IDX_A_CONTROL, 8'h00);
        wr(IDX_A_COUNT, 8'hFE);
        wr(IDX_A_CONTROL, 8'h01);
        repeat (4) @(posedge hclk);
        wr(IDX_A_CONTROL, 8'h00);
        xf(1'b0, IDX_FLAG, 8'h00, q);
        chk("ovf", q[FLAG_A_OVF_BIT], 1'b1);
        chk("irq", irq, 1'b1);
        wr(IDX_MASK, 8'h00);
        chk("irq", irq, 1'b0);
        wr(IDX_FLAG, 8'h02);
        xf(1'b0, IDX_FLAG, 8'h00, q);
        chk("ovf", q[FLAG_A_OVF_BIT], 1'b0);
        // timer b stopped, on core clock, then on fast timebase
        wr(IDX_PLL_CONTROL, 8'h00);
        wr(IDX_B_CONTROL_TWO, 8'h00);
        repeat (4) @(posedge hclk);
        xf(1'b0, IDX_B_COUNT, 8'h00, q1);
        repeat (20) @(posedge hclk);
        xf(1'b0, IDX_B_COUNT, 8'h00, q);
        chk("b_stop", q, q1);
        wr(IDX_B_CONTROL_TWO, 8'h01);
        repeat (20) @(posedge hclk);
        xf(1'b0, IDX_B_COUNT, 8'h00, q);
        chk("b_sync", q != q1, 1'b1);
        wr(IDX_PLL_CONTROL, 8'h04);
        repeat (10) @(posedge hclk);
        xf(1'b0, IDX_B_COUNT, 8'h00, q1);
        nf = 0;
        fast_run <= 1'b1;
        repeat (40) @(posedge hclk);
        fast_run <= 1'b0;
        repeat (10) @(posedge hclk);
        xf(1'b0, IDX_B_COUNT, 8'h00, q);
        chk("b_async", q, 8'(q1 + nf));
        wr(IDX_B_COUNT, 8'h5A);
        xf(1'b0, IDX_B_COUNT, 8'h00, q1);
        chk("b_delay", q1, q);
        repeat (6) @(posedge hclk);
        xf(1'b0, IDX_B_COUNT, 8'h00, q);
        chk("b_load", q, 8'h5A);
        give_verdict();
    end
endmodule // dtp_top_tb

// >>> inc/dtp_pkg.sv
// constants, field layouts and carriers for the dual timer front end
// assumes an ahb-lite slave with 32-bit data, registers one per word
package dtp_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_A_COUNT = 8'h32;
    localparam logic [7:0] IDX_A_CONTROL = 8'h33;
    localparam logic [7:0] IDX_B_CONTROL_ONE = 8'h30;
    localparam logic [7:0] IDX_B_CONTROL_TWO = 8'h2F;
    localparam logic [7:0] IDX_B_COUNT = 8'h2E;
    localparam logic [7:0] IDX_B_COMPARE_A = 8'h2D;
    localparam logic [7:0] IDX_B_COMPARE_B = 8'h2C;
    localparam logic [7:0] IDX_B_COMPARE_TOP = 8'h2B;
    localparam logic [7:0] IDX_PLL_CONTROL = 8'h29;
    localparam logic [7:0] IDX_FLAG = 8'h38;
    localparam logic [7:0] IDX_MASK = 8'h39;

    // field positions
    localparam int A_PRESCALE_CLEAR_BIT = 3;
    localparam int B_CTC_BIT = 7;
    localparam int B_PRESCALE_CLEAR_BIT = 6;
    localparam int ASYNC_ENABLE_BIT = 2;
    localparam int FLAG_A_OVF_BIT = 1;
    localparam int FLAG_B_OVF_BIT = 2;
    localparam int FLAG_B_MATCH_B_BIT = 5;
    localparam int FLAG_B_MATCH_A_BIT = 6;

    // reset values and counter maximum
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_COMPARE_TOP = 8'hFF;
    localparam logic [7:0] COUNT_MAX = 8'hFF;

    // timer a source select codes
    localparam logic [2:0] A_SRC_STOP = 3'h0;
    localparam logic [2:0] A_SRC_PIN_FALL = 3'h6;
    localparam logic [2:0] A_SRC_PIN_RISE = 3'h7;

    // prescaler widths and synchroniser depth
    localparam int A_PRESCALE_BITS = 10;
    localparam int B_PRESCALE_BITS = 14;
    localparam int SYNC_DEPTH = 2;

    // targets of a write carried into the timer b domain
    localparam logic [2:0] B_TGT_CONTROL_ONE = 3'h1;
    localparam logic [2:0] B_TGT_CONTROL_TWO = 3'h2;
    localparam logic [2:0] B_TGT_COUNT = 3'h3;
    localparam logic [2:0] B_TGT_COMPARE_A = 3'h4;
    localparam logic [2:0] B_TGT_COMPARE_B = 3'h5;
    localparam logic [2:0] B_TGT_COMPARE_TOP = 3'h6;

    // write passing through the input synchroniser
    typedef struct packed {
        logic valid;
        logic [2:0] target;
        logic [7:0] data;
    } dtp_wr_t;

    // timer b state passing through the output synchroniser
    typedef struct packed {
        logic [7:0] count;
        logic ovf;
        logic match_a;
        logic match_b;
    } dtp_stat_t;

    // bus transfer state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } dtp_bus_state_t;

    // prescaler tap index for timer a divided selects
    function automatic logic [3:0] dtp_a_tap(input logic [2:0] sel);
        case (sel)
            3'h2: dtp_a_tap = 4'h3;
            3'h3: dtp_a_tap = 4'h6;
            3'h4: dtp_a_tap = 4'h8;
            3'h5: dtp_a_tap = 4'hA;
            default: dtp_a_tap = 4'h0;
        endcase
    endfunction

endpackage

// >>> logic/dtp_prescaler.sv
// free-running prescaler with one tap per power of two
// assumes run gates counting and clear restarts from zero
`timescale 1ns/1ns
module dtp_prescaler
    import dtp_pkg::*;
#(
    parameter int WIDTH = 10
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic clear,
    input wire logic run,
    // tap k pulses once every 2**k active cycles
    output logic [WIDTH:0] tap
);

    logic [WIDTH-1:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // divider counter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_q <= '0;
        else if (clear)
            cnt_q <= '0;
        else if (run)
            cnt_q <= cnt_q + 1'b1;
    end

    // carry taps, held off while clearing
    assign tap[0] = run && !clear;
    for (genvar k = 1; k <= WIDTH; k++)
    begin : g_tap
        assign tap[k] = run && !clear && (&cnt_q[k-1:0]);
    end

endmodule // dtp_prescaler

// >>> logic/dtp_sync_stage.sv
// fixed-depth register chain used as a synchronisation delay
// assumes one clock; every stage resets to zero
`timescale 1ns/1ns
module dtp_sync_stage
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage_q [DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // shift chain
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < DEPTH; i++)
                stage_q[i] <= '0;
        end
        else
        begin
            stage_q[0] <= din;
            for (int i = 1; i < DEPTH; i++)
                stage_q[i] <= stage_q[i-1];
        end
    end

    assign dout = stage_q[DEPTH-1];

endmodule // dtp_sync_stage

// >>> logic/dtp_top.sv
// dual timer clocking front end with ahb-lite register slave
// assumes pins synchronous to hclk; fast timebase seen as a level
`timescale 1ns/1ns
module dtp_top
    import dtp_pkg::*;
#(
    parameter int SYNC_STAGES = SYNC_DEPTH
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // timer inputs
    input wire logic count_input_pin,
    input wire logic fast_peripheral_timebase,
    // interrupt request of timer a overflow
    output logic timer_a_ovf_irq
);

    // returns true when a word address hits a register index
    function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
        hit = (a[31:10] == 22'h0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations
    dtp_bus_state_t state_q;
    logic [31:0] addr_q;
    logic write_q;
    logic [31:0] hrdata_q;
    logic wr_en;
    logic [7:0] wdata;
    logic [7:0] a_count_q;
    logic [2:0] a_src_q;
    logic a_clear_q;
    logic pin_q;
    logic pin_prev_q;
    logic a_tick;
    logic [A_PRESCALE_BITS:0] a_tap;
    logic async_q;
    logic fast_q;
    logic fast_prev_q;
    logic [7:0] b_ctl1_q;
    logic [7:0] b_ctl2_q;
    logic [7:0] b_cmpa_q;
    logic [7:0] b_cmpb_q;
    logic [7:0] b_top_q;
    logic [7:0] b_ctl2_act_q;
    logic [7:0] b_cmpa_act_q;
    logic [7:0] b_cmpb_act_q;
    logic [7:0] b_top_act_q;
    logic [7:0] b_count_q;
    dtp_wr_t b_wr;
    dtp_wr_t b_wr_sync;
    dtp_wr_t b_apply;
    logic [$bits(dtp_wr_t)-1:0] b_wr_bits;
    logic [$bits(dtp_stat_t)-1:0] b_stat_bits;
    dtp_stat_t b_stat;
    dtp_stat_t b_stat_seen;
    logic [3:0] b_sel;
    logic b_src_tick;
    logic b_clear;
    logic [B_PRESCALE_BITS:0] b_tap;
    logic b_tick;
    logic [7:0] flag_q;
    logic [7:0] mask_q;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;

    ////////////////////////////////////////////////////////////////////////
    // bus: address phase, then one wait cycle, then data phase ends
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= ST_IDLE;
            addr_q <= 32'h0;
            write_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (hsel && hready && htrans[1])
                    begin
                        state_q <= ST_WAIT;
                        addr_q <= haddr;
                        write_q <= hwrite;
                    end
                end
                ST_WAIT:
                    state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    assign hreadyout = (state_q != ST_WAIT);
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign wr_en = (state_q == ST_WAIT) && write_q;
    assign wdata = hwdata[7:0];

    // read data registered in the wait cycle; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h0;
        else if (state_q == ST_WAIT && !write_q)
        begin
            hrdata_q <= 32'h0;
            if (hit(addr_q, IDX_A_COUNT))
                hrdata_q[7:0] <= a_count_q;
            if (hit(addr_q, IDX_A_CONTROL))
                hrdata_q[7:0] <= {5'h0, a_src_q};
            if (hit(addr_q, IDX_B_CONTROL_ONE))
                hrdata_q[7:0] <= b_ctl1_q;
            if (hit(addr_q, IDX_B_CONTROL_TWO))
                hrdata_q[7:0] <= b_ctl2_q;
            if (hit(addr_q, IDX_B_COMPARE_A))
                hrdata_q[7:0] <= b_cmpa_q;
            if (hit(addr_q, IDX_B_COMPARE_B))
                hrdata_q[7:0] <= b_cmpb_q;
            if (hit(addr_q, IDX_B_COMPARE_TOP))
                hrdata_q[7:0] <= b_top_q;
            if (hit(addr_q, IDX_B_COUNT))
                hrdata_q[7:0] <= b_stat_seen.count;
            if (hit(addr_q, IDX_PLL_CONTROL))
                hrdata_q[ASYNC_ENABLE_BIT] <= async_q;
            if (hit(addr_q, IDX_FLAG))
                hrdata_q[7:0] <= flag_q;
            if (hit(addr_q, IDX_MASK))
                hrdata_q[7:0] <= mask_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timer a control; clear bit stored only as a one-cycle pulse
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            a_src_q <= A_SRC_STOP;
            a_clear_q <= 1'b0;
        end
        else
        begin
            a_clear_q <= 1'b0;
            if (wr_en && hit(addr_q, IDX_A_CONTROL))
            begin
                a_src_q <= wdata[2:0];
                a_clear_q <= wdata[A_PRESCALE_CLEAR_BIT];
            end
        end
    end

    // count pin sampled on each core edge, previous kept for edges
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end
        else
        begin
            pin_q <= count_input_pin;
            pin_prev_q <= pin_q;
        end
    end

    // timer a prescaler
    dtp_prescaler #(
        .WIDTH(A_PRESCALE_BITS)
    ) u_a_prescale (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(a_clear_q),
        .run(a_src_q != A_SRC_STOP),
        .tap(a_tap)
    );

    // timer a tick selection
    always_comb
    begin
        case (a_src_q)
            A_SRC_STOP: a_tick = 1'b0;
            A_SRC_PIN_FALL: a_tick = pin_prev_q && !pin_q;
            A_SRC_PIN_RISE: a_tick = !pin_prev_q && pin_q;
            default: a_tick = a_tap[dtp_a_tap(a_src_q)];
        endcase
    end

    // timer a counter; a write wins over a tick in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            a_count_q <= RST_BYTE;
        else if (wr_en && hit(addr_q, IDX_A_COUNT))
            a_count_q <= wdata;
        else if (a_tick)
            a_count_q <= a_count_q + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // async enable and fast timebase edge detection
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            async_q <= 1'b0;
            fast_q <= 1'b0;
            fast_prev_q <= 1'b0;
        end
        else
        begin
            if (wr_en && hit(addr_q, IDX_PLL_CONTROL))
                async_q <= wdata[ASYNC_ENABLE_BIT];
            fast_q <= fast_peripheral_timebase;
            fast_prev_q <= fast_q;
        end
    end

    // software-visible copies of timer b control and compare
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            b_ctl1_q <= RST_BYTE;
            b_ctl2_q <= RST_BYTE;
            b_cmpa_q <= RST_BYTE;
            b_cmpb_q <= RST_BYTE;
            b_top_q <= RST_COMPARE_TOP;
        end
        else if (wr_en)
        begin
            if (hit(addr_q, IDX_B_CONTROL_ONE))
                b_ctl1_q <= wdata;
            if (hit(addr_q, IDX_B_CONTROL_TWO))
                b_ctl2_q <= {wdata[B_CTC_BIT], 3'h0, wdata[3:0]};
            if (hit(addr_q, IDX_B_COMPARE_A))
                b_cmpa_q <= wdata;
            if (hit(addr_q, IDX_B_COMPARE_B))
                b_cmpb_q <= wdata;
            if (hit(addr_q, IDX_B_COMPARE_TOP))
                b_top_q <= wdata;
        end
    end

    // write descriptor bound for the timer b domain
    always_comb
    begin
        b_wr = '0;
        b_wr.data = wdata;
        if (wr_en)
        begin
            b_wr.valid = 1'b1;
            if (hit(addr_q, IDX_B_CONTROL_ONE))
                b_wr.target = B_TGT_CONTROL_ONE;
            else if (hit(addr_q, IDX_B_CONTROL_TWO))
                b_wr.target = B_TGT_CONTROL_TWO;
            else if (hit(addr_q, IDX_B_COUNT))
                b_wr.target = B_TGT_COUNT;
            else if (hit(addr_q, IDX_B_COMPARE_A))
                b_wr.target = B_TGT_COMPARE_A;
            else if (hit(addr_q, IDX_B_COMPARE_B))
                b_wr.target = B_TGT_COMPARE_B;
            else if (hit(addr_q, IDX_B_COMPARE_TOP))
                b_wr.target = B_TGT_COMPARE_TOP;
            else
                b_wr.valid = 1'b0;
        end
    end

    // input synchroniser; bypassed in synchronous mode
    dtp_sync_stage #(
        .WIDTH($bits(dtp_wr_t)),
        .DEPTH(SYNC_STAGES)
    ) u_in_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(b_wr),
        .dout(b_wr_bits)
    );
    assign b_wr_sync = dtp_wr_t'(b_wr_bits);
    assign b_apply = async_q ? b_wr_sync : b_wr;

    // active timer b settings, updated from the applied write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            b_ctl2_act_q <= RST_BYTE;
            b_cmpa_act_q <= RST_BYTE;
            b_cmpb_act_q <= RST_BYTE;
            b_top_act_q <= RST_COMPARE_TOP;
        end
        else if (b_apply.valid)
        begin
            case (b_apply.target)
                B_TGT_CONTROL_TWO: b_ctl2_act_q <= b_apply.data;
                B_TGT_COMPARE_A: b_cmpa_act_q <= b_apply.data;
                B_TGT_COMPARE_B: b_cmpb_act_q <= b_apply.data;
                B_TGT_COMPARE_TOP: b_top_act_q <= b_apply.data;
                default: b_top_act_q <= b_top_act_q;
            endcase
        end
    end

    // timer b prescaler: fast rising edges in async mode, every core cycle else
    assign b_sel = b_ctl2_act_q[3:0];
    assign b_src_tick = async_q ? (fast_q && !fast_prev_q) : 1'b1;
    assign b_clear = b_apply.valid && (b_apply.target == B_TGT_CONTROL_TWO)
        && b_apply.data[B_PRESCALE_CLEAR_BIT];

    dtp_prescaler #(
        .WIDTH(B_PRESCALE_BITS)
    ) u_b_prescale (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(b_clear),
        .run(b_src_tick && (b_sel != 4'h0)),
        .tap(b_tap)
    );
    assign b_tick = (b_sel != 4'h0) && b_tap[b_sel - 4'h1];

    // timer b counter and its events
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            b_count_q <= RST_BYTE;
        else if (b_apply.valid && b_apply.target == B_TGT_COUNT)
            b_count_q <= b_apply.data;
        else if (b_tick)
        begin
            if (b_ctl2_act_q[B_CTC_BIT] && b_count_q == b_top_act_q)
                b_count_q <= RST_BYTE;
            else
                b_count_q <= b_count_q + 8'h01;
        end
    end

    always_comb
    begin
        b_stat.count = b_count_q;
        b_stat.ovf = b_tick && (b_count_q == COUNT_MAX
            || (b_ctl2_act_q[B_CTC_BIT] && b_count_q == b_top_act_q));
        b_stat.match_a = b_tick && (b_count_q == b_cmpa_act_q);
        b_stat.match_b = b_tick && (b_count_q == b_cmpb_act_q);
    end

    // output synchroniser toward the register side
    dtp_sync_stage #(
        .WIDTH($bits(dtp_stat_t)),
        .DEPTH(SYNC_STAGES)
    ) u_out_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(b_stat),
        .dout(b_stat_bits)
    );
    assign b_stat_seen = dtp_stat_t'(b_stat_bits);

    ////////////////////////////////////////////////////////////////////////
    // shared flags: write one clears, hardware set wins
    always_comb
    begin
        flag_set = 8'h00;
        flag_set[FLAG_A_OVF_BIT] = a_tick && (a_count_q == COUNT_MAX)
            && !(wr_en && hit(addr_q, IDX_A_COUNT));
        flag_set[FLAG_B_OVF_BIT] = b_stat_seen.ovf;
        flag_set[FLAG_B_MATCH_A_BIT] = b_stat_seen.match_a;
        flag_set[FLAG_B_MATCH_B_BIT] = b_stat_seen.match_b;
        flag_clr = (wr_en && hit(addr_q, IDX_FLAG)) ? wdata : 8'h00;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            flag_q <= RST_BYTE;
            mask_q <= RST_BYTE;
        end
        else
        begin
            flag_q <= (flag_q & ~flag_clr) | flag_set;
            if (wr_en && hit(addr_q, IDX_MASK))
                mask_q <= wdata;
        end
    end

    // overflow request, gated by its enable
    assign timer_a_ovf_irq = flag_q[FLAG_A_OVF_BIT]
        && mask_q[FLAG_A_OVF_BIT];

endmodule // dtp_top
